/* File: rtl/rcc_classifier.v */
// rcc_classifier.v: command word classifier of a remote terminal.
// assumes a decoder presents each word with a one-cycle strobe and that the
// legality bit is returned by shared memory within the cycle of its request.
//
// Behaviour
// - a word is valid only with good sync, coding, bit count and odd parity.
// - a valid command keeps its sixteen data bits after sync and parity removal.
// - command holds address, direction, subaddress and count or mode fields.
// - own latched address or address 31 selects this terminal.
// - broadcast-invalid setting makes address 31 commands ignored.
// - subaddress 1 to 30 gives direction and count, zero meaning 32.
// - subaddress 0 or 31 turns the low field into a mode code.
// - mode codes 16 to 31 carry one data word per direction.
// - mode codes 0 to 15 need direction one, else undefined.
// - twenty-two undefined mode combinations are recognised.
// - undefined-invalid setting makes undefined mode commands fully ignored.
// - undefined-invalid cleared at reset; legality lookup then decides.
// - legal undefined mode gives clear status, with data for 17, 20, 21 transmit.
// - illegal mode command gives status with message error, no transmit data; receive data flag still set.
// - twenty-seven reserved mode combinations follow the legality lookup.
// - mode data words use fixed storage per mode code.
// - separate transmit and receive descriptor per subaddress with buffer method.
// - transfer between terminals is receive then transmit command, second not 31.
// - a pair with a mode subaddress is ignored with no status update.
// - pair to us first and other second sets the relay flag.
// - pair to us second only is recorded as an ordinary transmit.
// - each lone command or command pair fetches one legality bit; one means message error.
// - legality table is 256 words at a fixed range, zero after reset.
`timescale 1ns/100ps
`default_nettype none
`include "rcc_defs.vh"
module rcc_classifier (
   // clock and reset
   input wire ref_clk_in,
   input wire reset_in,
   // received word from decoder
   input wire word_stb_in,
   input wire word_cmd_sync_in,
   input wire [15:0] word_data_in,
   input wire word_parity_in,
   input wire word_sync_ok_in,
   input wire word_coding_ok_in,
   input wire word_count_ok_in,
   // configuration
   input wire [4:0] own_addr_in,
   input wire broadcast_invalid_sel_in,
   input wire undefined_mode_invalid_sel_in,
   // legality lookup
   output wire ill_req_out,
   output reg [8:0] ill_addr_out,
   output reg [3:0] ill_bit_out,
   input wire ill_bit_in,
   // decision
   output reg done_out,
   output reg respond_out,
   output reg send_status_out,
   output reg msg_error_out,
   output reg status_update_out,
   output reg mode_cmd_out,
   output reg [4:0] mode_code_out,
   output reg mode_data_tx_out,
   output reg mode_data_rx_out,
   output reg [15:0] mode_data_addr_out,
   output reg tr_out,
   output reg [5:0] word_count_out,
   output reg [4:0] subaddress_field_out,
   output reg broadcast_out,
   output reg relay_transfer_flag_out,
   output reg [15:0] cmd_word_out
);
   localparam [3:0] ST_IDLE = 4'h1;
   localparam [3:0] ST_PAIR = 4'h2;
   localparam [3:0] ST_LOOK = 4'h4;
   localparam [3:0] ST_DONE = 4'h8;

   reg [3:0] state_q;
   reg [3:0] state_d;
   reg [15:0] cmd_q;
   reg [15:0] first_q;
   reg pair_q;
   reg first_mine_q;
   reg mine_q;
   reg bcast_q;
   wire word_valid;
   wire has_data;
   wire undefined;
   wire reserved;
   wire [4:0] ta_in;
   wire [4:0] sa_in;
   wire [4:0] sa_cmd;
   wire [4:0] lo_cmd;
   wire tr_cmd;
   wire is_mode_cmd;
   wire addr_mine;
   wire addr_bcast;
   wire take_cmd;
   wire pair_cmd;

   // returns true for a mode subaddress
   function is_mode_sa;
      input [4:0] sa;
      begin
         is_mode_sa = (sa == `RCC_SA_MODE_LO) || (sa == `RCC_SA_MODE_HI);
      end
   endfunction

   // legality table word and bit for a command; a broadcast selects the lower half
   function [12:0] ill_loc;
      input [15:0] cmd;
      input bc;
      begin
         ill_loc = {`RCC_ILL_BASE | {1'b0, ~bc, cmd[`RCC_TR_BIT], cmd[`RCC_SA_MSB:`RCC_SA_LSB], cmd[`RCC_WC_MSB]},
            cmd[`RCC_WC_MSB - 1:`RCC_WC_LSB]};
      end
   endfunction

   rcc_word_check u_check (
      .data_in(word_data_in),
      .parity_in(word_parity_in),
      .sync_ok_in(word_sync_ok_in),
      .coding_ok_in(word_coding_ok_in),
      .count_ok_in(word_count_ok_in),
      .valid_out(word_valid)
   );

   rcc_mode_class u_mode (
      .code_in(lo_cmd),
      .tr_in(tr_cmd),
      .has_data_out(has_data),
      .undefined_out(undefined),
      .reserved_out(reserved)
   );

   assign ta_in = word_data_in[`RCC_TA_MSB:`RCC_TA_LSB];
   assign sa_in = word_data_in[`RCC_SA_MSB:`RCC_SA_LSB];
   assign sa_cmd = cmd_q[`RCC_SA_MSB:`RCC_SA_LSB];
   assign lo_cmd = cmd_q[`RCC_WC_MSB:`RCC_WC_LSB];
   assign tr_cmd = cmd_q[`RCC_TR_BIT];
   assign is_mode_cmd = is_mode_sa(sa_cmd);
   assign addr_mine = ta_in == own_addr_in;
   assign addr_bcast = (ta_in == `RCC_BCAST_ADDR) && !broadcast_invalid_sel_in;
   // only valid command-sync words are kept
   assign take_cmd = word_stb_in && word_cmd_sync_in && word_valid;
   // transmit command not to address 31 completes a pair
   assign pair_cmd = take_cmd && word_data_in[`RCC_TR_BIT] && (ta_in != `RCC_BCAST_ADDR);
   assign ill_req_out = state_q == ST_LOOK;

   always @*
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
         begin
            if (take_cmd && !word_data_in[`RCC_TR_BIT])
               state_d = ST_PAIR;
            else if (take_cmd)
               state_d = ST_LOOK;
         end
         ST_PAIR:
         begin
            if (word_stb_in)
               state_d = ST_LOOK;
         end
         ST_LOOK:
            state_d = ST_DONE;
         ST_DONE:
            state_d = ST_IDLE;
         default:
            state_d = ST_IDLE;
      endcase
   end

   always @(posedge ref_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         state_q <= ST_IDLE;
         cmd_q <= 16'h0000;
         first_q <= 16'h0000;
         pair_q <= 1'b0;
         first_mine_q <= 1'b0;
         mine_q <= 1'b0;
         bcast_q <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         if (state_q == ST_IDLE && take_cmd)
         begin
            cmd_q <= word_data_in;
            first_q <= word_data_in;
            pair_q <= 1'b0;
            first_mine_q <= addr_mine || addr_bcast;
            mine_q <= addr_mine || addr_bcast;
            bcast_q <= addr_bcast && !addr_mine;
         end
         else if (state_q == ST_PAIR && word_stb_in)
         begin
            // a contiguous transmit command makes a pair
            if (pair_cmd)
            begin
               pair_q <= 1'b1;
               cmd_q <= word_data_in;
               mine_q <= addr_mine;
               bcast_q <= 1'b0;
               // receive side keeps its own command
               if (first_mine_q && !addr_mine)
                  cmd_q <= first_q;
               // mode subaddress in either word kills the pair
               if (is_mode_sa(sa_in) || is_mode_sa(first_q[`RCC_SA_MSB:`RCC_SA_LSB]))
               begin
                  first_mine_q <= 1'b0;
                  mine_q <= 1'b0;
               end
            end
         end
      end
   end

   // legality word address and bit index
   always @(posedge ref_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         ill_addr_out <= 9'h000;
         ill_bit_out <= 4'h0;
      end
      else if (state_q == ST_IDLE && take_cmd)
      begin
         // lone command, broadcast only when not also our own address
         {ill_addr_out, ill_bit_out} <= ill_loc(word_data_in, addr_bcast && !addr_mine);
      end
      else if (state_q == ST_PAIR && pair_cmd)
      begin
         // index the command that this terminal acts on
         {ill_addr_out, ill_bit_out} <= ill_loc((first_mine_q && !addr_mine) ? first_q : word_data_in, 1'b0);
      end
   end

   // decision registered at the end of the lookup cycle
   always @(posedge ref_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         done_out <= 1'b0;
         respond_out <= 1'b0;
         send_status_out <= 1'b0;
         msg_error_out <= 1'b0;
         status_update_out <= 1'b0;
         mode_cmd_out <= 1'b0;
         mode_code_out <= 5'h00;
         mode_data_tx_out <= 1'b0;
         mode_data_rx_out <= 1'b0;
         mode_data_addr_out <= 16'h0000;
         tr_out <= 1'b0;
         word_count_out <= 6'h00;
         subaddress_field_out <= 5'h00;
         broadcast_out <= 1'b0;
         relay_transfer_flag_out <= 1'b0;
         cmd_word_out <= 16'h0000;
      end
      else
      begin
         done_out <= 1'b0;
         if (state_q == ST_LOOK)
         begin
            done_out <= 1'b1;
            cmd_word_out <= cmd_q;
            // direction and subaddress pick the descriptor
            tr_out <= tr_cmd;
            subaddress_field_out <= sa_cmd;
            broadcast_out <= bcast_q;
            mode_cmd_out <= is_mode_cmd;
            mode_code_out <= lo_cmd;
            word_count_out <= (lo_cmd == `RCC_WC_ZERO) ? `RCC_WC_FULL : {1'b0, lo_cmd};
            // relay flag only for receive side of a pair
            relay_transfer_flag_out <= pair_q && first_mine_q && !mine_q;
            // undefined mode ignored only when so configured
            if (!(mine_q || (pair_q && first_mine_q)) || (is_mode_cmd && undefined && undefined_mode_invalid_sel_in))
            begin
               respond_out <= 1'b0;
               send_status_out <= 1'b0;
               msg_error_out <= 1'b0;
               status_update_out <= 1'b0;
               mode_data_tx_out <= 1'b0;
               mode_data_rx_out <= 1'b0;
            end
            else
            begin
               respond_out <= 1'b1;
               status_update_out <= 1'b1;
               send_status_out <= !bcast_q;
               msg_error_out <= ill_bit_in;
               mode_data_tx_out <= is_mode_cmd && has_data && tr_cmd && !ill_bit_in;
               mode_data_rx_out <= is_mode_cmd && has_data && !tr_cmd;
            end
            mode_data_addr_out <= `RCC_MODE_DATA_BASE | {10'h000, tr_cmd, lo_cmd};
         end
      end
   end
endmodule
`default_nettype wire

/* File: rtl/rcc_defs.vh */
// rcc_defs.vh: constants for the remote terminal command classifier.
// assumes inclusion by bare name from design files.
`ifndef RCC_DEFS_VH
`define RCC_DEFS_VH
`define RCC_BCAST_ADDR 5'h1F
`define RCC_SA_MODE_LO 5'h00
`define RCC_SA_MODE_HI 5'h1F
`define RCC_TA_MSB 15
`define RCC_TA_LSB 11
`define RCC_TR_BIT 10
`define RCC_SA_MSB 9
`define RCC_SA_LSB 5
`define RCC_WC_MSB 4
`define RCC_WC_LSB 0
`define RCC_WC_MSB_BIT 4
`define RCC_WC_ZERO 5'h00
`define RCC_WC_FULL 6'h20
`define RCC_MODE_CODE_SIXTEEN 5'h10
`define RCC_MC17 5'h11
`define RCC_MC18 5'h12
`define RCC_MC19 5'h13
`define RCC_MC20 5'h14
`define RCC_MC21 5'h15
`define RCC_MC22 5'h16
`define RCC_MC9 5'h09
`define RCC_MC15 5'h0F
`define RCC_ILL_BASE 9'h100
`define RCC_ILL_WORDS 9'h100
`define RCC_MODE_DATA_BASE 16'h0200
`endif

/* File: rtl/rcc_word_check.v */
// rcc_word_check.v: validity check of one received bus word.
// assumes decoder flags for sync, coding and bit count arrive with the word.
`timescale 1ns/100ps
`default_nettype none
module rcc_word_check (
   // received word
   input wire [15:0] data_in,
   input wire parity_in,
   input wire sync_ok_in,
   input wire coding_ok_in,
   input wire count_ok_in,
   // verdict
   output wire valid_out
);
   assign valid_out = sync_ok_in & coding_ok_in & count_ok_in & ((^data_in) ^ parity_in);
endmodule
`default_nettype wire

/* File: rtl/rcc_mode_class.v */
// rcc_mode_class.v: classification of a mode code and direction.
// assumes a pure combinational use by the classifier.
`timescale 1ns/100ps
`default_nettype none
`include "rcc_defs.vh"
module rcc_mode_class (
   // mode command fields
   input wire [4:0] code_in,
   input wire tr_in,
   // class flags
   output wire has_data_out,
   output wire undefined_out,
   output wire reserved_out
);
   // codes 16 and up carry one word
   assign has_data_out = code_in >= `RCC_MODE_CODE_SIXTEEN;
   assign undefined_out = tr_in ? (code_in == `RCC_MC17 || code_in == `RCC_MC20 || code_in == `RCC_MC21) :
      (code_in <= `RCC_MC15 || code_in == `RCC_MODE_CODE_SIXTEEN || code_in == `RCC_MC18 || code_in == `RCC_MC19);
   assign reserved_out = (code_in >= `RCC_MC22) || (tr_in && code_in >= `RCC_MC9 && code_in <= `RCC_MC15);
endmodule
`default_nettype wire

/* File: tb/rcc_ill_model.sv */
// rcc_ill_model.sv: legality table seen from the classifier.
// assumes the bench loads table words through set_word before a fetch.
`timescale 1ns/100ps
`default_nettype none
module rcc_ill_model (
   // clock
   input wire logic ref_clk_in,
   // fetch
   input wire logic ill_req_in,
   input wire logic [8:0] ill_addr_in,
   input wire logic [3:0] ill_bit_in,
   output logic ill_bit_out
);
   logic [15:0] table_q [0:255];
   logic idle_q = 1'b0;
   initial
      for (int i = 0; i < 256; i++)
         table_q[i] = 16'h0000;
   always @(posedge ref_clk_in)
      idle_q <= ~idle_q;
   task set_word(input logic [7:0] a, input logic [15:0] v);
      table_q[a] = v;
   endtask
   // one bit per fetch inside the table range, junk elsewhere
   assign ill_bit_out = (ill_req_in && ill_addr_in[8]) ? table_q[ill_addr_in[7:0]][ill_bit_in] : idle_q;
endmodule
`default_nettype wire

/* File: tb/rcc_classifier_monitor.sv */
// rcc_classifier_monitor.sv: assertions on the classifier ports.
// assumes binding to rcc_classifier, port names matched by name.
`timescale 1ns/100ps
`default_nettype none
module rcc_mon (
   // clock and reset
   input wire logic ref_clk_in, reset_in,
   // received word and settings
   input wire logic word_stb_in, word_cmd_sync_in, word_parity_in, word_sync_ok_in,
   input wire logic word_coding_ok_in, word_count_ok_in, broadcast_invalid_sel_in,
   input wire logic undefined_mode_invalid_sel_in, ill_bit_in,
   input wire logic [15:0] word_data_in,
   // decision
   input wire logic ill_req_out, done_out, respond_out, send_status_out, msg_error_out,
   input wire logic status_update_out, mode_cmd_out, mode_data_tx_out, mode_data_rx_out,
   input wire logic tr_out, broadcast_out, relay_transfer_flag_out,
   input wire logic [4:0] mode_code_out,
   input wire logic [5:0] word_count_out,
   input wire logic [15:0] mode_data_addr_out, cmd_word_out
);
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (reset_in);
   wire logic good = word_stb_in & word_cmd_sync_in & word_sync_ok_in & word_coding_ok_in
      & word_count_ok_in & (^{word_data_in, word_parity_in});
   wire logic mode = cmd_word_out[9:5] == 5'h00 || cmd_word_out[9:5] == 5'h1F;
   AST_TX_ANSWER: assert property (good && word_data_in[10] |-> ##2 done_out)
      else $error("transmit command not answered in two cycles");
   AST_BCAST_QUIET: assert property (done_out && broadcast_out |-> !send_status_out)
      else $error("status sent for broadcast");
   AST_BCAST_INV: assert property (done_out && broadcast_invalid_sel_in && cmd_word_out[15:11] == 5'h1F
      |-> !respond_out && !status_update_out)
      else $error("broadcast accepted while disabled");
   AST_WORD_COUNT: assert property (done_out && respond_out && !mode_cmd_out
      |-> word_count_out == {cmd_word_out[4:0] == 5'h00, cmd_word_out[4:0]})
      else $error("word count wrong");
   AST_MODE_SPLIT: assert property (done_out && respond_out
      |-> mode_cmd_out == mode && (!mode || mode_code_out == cmd_word_out[4:0]))
      else $error("mode split wrong");
   AST_UNDEF_OFF: assert property (done_out && undefined_mode_invalid_sel_in && mode && !cmd_word_out[10]
      && !cmd_word_out[4] |-> !respond_out && !status_update_out)
      else $error("undefined mode command answered");
   AST_ILLEGAL: assert property (done_out && respond_out && $past(ill_req_out && ill_bit_in)
      |-> msg_error_out && !mode_data_tx_out)
      else $error("illegal command without message error");
   AST_DATA_ADDR: assert property (done_out && (mode_data_tx_out || mode_data_rx_out)
      |-> mode_data_addr_out == 16'h0200 + {10'h000, cmd_word_out[10], cmd_word_out[4:0]})
      else $error("mode data address wrong");
   AST_DATA_DIR: assert property (done_out && respond_out && mode_cmd_out && !msg_error_out
      |-> mode_data_tx_out == (tr_out && mode_code_out[4]) && mode_data_rx_out == (!tr_out && mode_code_out[4]))
      else $error("mode data direction wrong");
   cover property (done_out && broadcast_out);
   cover property (done_out && msg_error_out);
   cover property (done_out && relay_transfer_flag_out);
endmodule
bind rcc_classifier rcc_mon mon (.*);
`default_nettype wire

/* File: tb/tb.sv */
// tb.sv: classifier bench with a legality table model.
// assumes own terminal address 5 and a design that answers within four cycles.
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic stb = 1'b0, cs = 1'b0, par = 1'b0, pbad = 1'b0, ok = 1'b1;
   logic bi = 1'b0, ui = 1'b0;
   logic [15:0] wd = 16'h0000;
   wire logic irq, ibit, done, resp, sst, merr, supd, mcmd, mtx, mrx, tr, bc, rel;
   wire logic [4:0] mc, sa;
   wire logic [5:0] wc;
   wire logic [15:0] mda, cwo;
   wire logic [8:0] ia;
   wire logic [3:0] ib;
   int bad_count = 0;
   int check_count = 0;
   int ndone = 0;
   always #50 clk = ~clk;
   always @(negedge clk)
      if (done === 1'b1)
         ndone++;
   rcc_ill_model far (.ref_clk_in(clk), .ill_req_in(irq), .ill_addr_in(ia), .ill_bit_in(ib), .ill_bit_out(ibit));
   rcc_classifier dut (.ref_clk_in(clk), .reset_in(rst), .word_stb_in(stb), .word_cmd_sync_in(cs),
      .word_data_in(wd), .word_parity_in(par), .word_sync_ok_in(ok), .word_coding_ok_in(ok),
      .word_count_ok_in(ok), .own_addr_in(5'h05), .broadcast_invalid_sel_in(bi),
      .undefined_mode_invalid_sel_in(ui), .ill_req_out(irq), .ill_addr_out(ia), .ill_bit_out(ib),
      .ill_bit_in(ibit), .done_out(done), .respond_out(resp), .send_status_out(sst), .msg_error_out(merr),
      .status_update_out(supd), .mode_cmd_out(mcmd), .mode_code_out(mc), .mode_data_tx_out(mtx),
      .mode_data_rx_out(mrx), .mode_data_addr_out(mda), .tr_out(tr), .word_count_out(wc),
      .subaddress_field_out(sa), .broadcast_out(bc), .relay_transfer_flag_out(rel), .cmd_word_out(cwo));
   function logic [15:0] cw(input logic [4:0] t, input logic r, input logic [4:0] s, input logic [4:0] w);
      return {t, r, s, w};
   endfunction
   task chk(input string n, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e)
      begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", n, e, g);
      end
   endtask
   task end_of_test;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   task word(input logic c, input logic [15:0] d);
      @(negedge clk);
      stb = 1'b1;
      cs = c;
      wd = d;
      par = ~^d ^ pbad;
      @(negedge clk);
      stb = 1'b0;
   endtask
   // receive commands are followed by one more word
   task msg(input logic [15:0] a, input logic s2, input logic [15:0] b);
      ndone = 0;
      word(1'b1, a);
      if (a[10] == 1'b0)
         word(s2, b);
      repeat (4) @(negedge clk);
      chk("done count", 1, ndone);
   endtask
   task t_sub;
      msg(cw(5'h05, 1'b1, 5'h03, 5'h00), 1'b0, 16'h0000);
      chk("tx fields", {1'b1, 6'h20, 5'h03, 1'b0, 1'b1}, {tr, wc, sa, merr, sst});
      chk("tx cmd", 16'h2C60, cwo);
      msg(cw(5'h05, 1'b0, 5'h1E, 5'h1F), 1'b0, 16'h1234);
      chk("rx fields", {1'b0, 6'h1F, 5'h1E, 1'b1}, {tr, wc, sa, supd});
   endtask
   task t_invalid;
      ndone = 0;
      pbad = 1'b1;
      word(1'b1, cw(5'h05, 1'b1, 5'h03, 5'h01));
      pbad = 1'b0;
      ok = 1'b0;
      word(1'b1, cw(5'h05, 1'b1, 5'h03, 5'h01));
      ok = 1'b1;
      repeat (4) @(negedge clk);
      chk("bad word done", 0, ndone);
   endtask
   task t_addr;
      msg(cw(5'h07, 1'b1, 5'h03, 5'h01), 1'b0, 16'h0000);
      chk("other terminal", 0, {resp, supd});
      msg(cw(5'h1F, 1'b0, 5'h03, 5'h02), 1'b0, 16'h00FF);
      chk("broadcast", 3'b101, {bc, sst, supd});
      bi = 1'b1;
      msg(cw(5'h1F, 1'b0, 5'h03, 5'h02), 1'b0, 16'h00FF);
      chk("broadcast off", 0, {resp, supd});
      bi = 1'b0;
   endtask
   task t_mode;
      logic u;
      for (int k = 0; k < 128; k++)
      begin
         ui = k[6];
         u = k[5] ? (k[4:0] == 17 || k[4:0] == 20 || k[4:0] == 21) : (k[4:0] < 17 || k[4:0] == 18 || k[4:0] == 19);
         msg(cw(5'h05, k[5], {5{k[0]}}, k[4:0]), 1'b0, 16'hA5A5);
         chk("mode respond", !(ui && u), resp);
         chk("mode status", !(ui && u), supd);
         if (!(ui && u))
         begin
            chk("mode code", {1'b1, k[4:0]}, {mcmd, mc});
            chk("mode data", {k[5] & k[4], ~k[5] & k[4], 1'b0}, {mtx, mrx, merr});
         end
      end
      ui = 1'b0;
   endtask
   task t_ill;
      far.set_word(8'hC1, 16'h0002);
      far.set_word(8'hC6, 16'h0010);
      far.set_word(8'h86, 16'h0004);
      msg(cw(5'h05, 1'b1, 5'h00, 5'h11), 1'b0, 16'h0000);
      chk("illegal mode", 4'b1110, {merr, sst, supd, mtx});
      chk("mode lookup", {9'h1C1, 4'h1}, {ia, ib});
      msg(cw(5'h05, 1'b1, 5'h00, 5'h10), 1'b0, 16'h0000);
      chk("legal mode", 2'b01, {merr, mtx});
      msg(cw(5'h05, 1'b1, 5'h03, 5'h04), 1'b0, 16'h0000);
      chk("illegal sub", {1'b1, 9'h1C6, 4'h4}, {merr, ia, ib});
      msg(cw(5'h1F, 1'b0, 5'h03, 5'h02), 1'b0, 16'h00FF);
      chk("broadcast lookup", {1'b0, 9'h106, 4'h2}, {merr, ia, ib});
      msg(cw(5'h05, 1'b0, 5'h03, 5'h02), 1'b0, 16'h00FF);
      chk("receive lookup", {1'b1, 9'h186, 4'h2}, {merr, ia, ib});
      far.set_word(8'hC1, 16'h0000);
      far.set_word(8'hC6, 16'h0000);
      far.set_word(8'h86, 16'h0000);
   endtask
   task t_pair;
      msg(cw(5'h05, 1'b0, 5'h02, 5'h03), 1'b1, cw(5'h09, 1'b1, 5'h04, 5'h03));
      chk("relay rx", 2'b11, {rel, resp});
      chk("relay rx lookup", {9'h184, 4'h3}, {ia, ib});
      msg(cw(5'h09, 1'b0, 5'h02, 5'h03), 1'b1, cw(5'h05, 1'b1, 5'h04, 5'h03));
      chk("relay tx", 3'b011, {rel, resp, tr});
      chk("relay tx lookup", {9'h1C8, 4'h3}, {ia, ib});
      msg(cw(5'h05, 1'b0, 5'h02, 5'h03), 1'b1, cw(5'h09, 1'b1, 5'h00, 5'h03));
      chk("relay mode", 0, {resp, supd});
   endtask
   initial
   begin
      repeat (6) @(negedge clk);
      chk("reset", 0, {done, resp, supd});
      rst = 1'b0;
      t_sub;
      t_invalid;
      t_addr;
      t_mode;
      t_ill;
      t_pair;
      end_of_test;
   end
   initial
   begin
      #2000000;
      bad_count++;
      end_of_test;
   end
endmodule
`default_nettype wire
